/* logic/tmsp_port.sv */
/*
  Multiplexed serial port for a shared four-wire bus, with APB registers
  and one level interrupt.
  Assumes the bus clock and frame sync come from outside and are slow
  against clk_i (at least four clk_i cycles per half period).
*/
// Design decisions made here: the address map and the APB register port.
// Contract
// - Slot register bits 0-7 enable transmit per slot; 8-15 reserved.
// - Address register: low byte own receive address, high byte destination.
// - Sender drives destination on address line; matching devices capture data.
// - All data uses one shared data line from joined receive/transmit pins.
// - One shared clock line formed by tying receive and transmit clocks.
// - Receive shift register collects bits, then copies into receive holding.
// - Copy into receive holding sets the receive flag.
// - Transmit holding word is copied into the transmit shift register.
// - In multiprocessing mode the receive holding register is unreachable.
// - In multiprocessing mode the transmit holding register is unreachable.
// - Control register bit 0 selects multiprocessing mode.
// - Address status register reports address line and slot timing.
// - Moving transmit holding into shift register sets the transmit flag.
// - One control bit enables the multiplexed port.
// - Devices take turns in slots; a sender may address any device set.
`timescale 1ns/1ns
`default_nettype none
module tmsp_port
  import tmsp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  input  wire logic        shared_serial_clock_i,
  input  wire logic        frame_sync_i,
  input  wire logic        mux_receive_data_pin_i,
  output var  logic        mux_transmit_data_pin_o,
  output var  logic        data_oe_n_o,
  input  wire logic        shared_address_line_i,
  output var  logic        address_out_o,
  output var  logic        address_oe_n_o,
  output var  logic        irq_o
);

  logic [15:0]            ctrl_r;
  logic [7:0]             slot_en_r;
  logic [15:0]            addr_pair_r;
  logic [15:0]            rx_hold_r;
  logic [15:0]            tx_hold_r;
  logic                   tx_full_r;
  logic [1:0]             flag_r;
  logic [1:0]             mask_r;
  logic [2:0]             clk_sy_r;
  logic [1:0]             fs_sy_r;
  logic [1:0]             din_sy_r;
  logic [1:0]             ain_sy_r;
  logic [3:0]             bit_r;
  logic [2:0]             slot_r;
  logic [15:0]            rx_shift_r;
  logic [7:0]             rx_addr_r;
  logic [7:0]             last_addr_r;
  logic                   last_match_r;
  logic [15:0]            tx_shift_r;
  logic [7:0]             tx_addr_r;
  tmsp_tx_st_t            tx_st_r;
  logic                   rd_ok_r;
  tmsp_ev_t               ev;
  logic                   mode;
  logic                   rise;
  logic                   fall;
  logic [3:0]             nbit;
  logic [2:0]             nslot;
  logic                   setup;
  logic                   wr_en;
  logic                   reg_hit;
  logic [31:0]            rd_val;
  logic                   tx_start;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign mode  = ctrl_r[TMSP_MODE_BIT];
  assign rise  = clk_sy_r[1] & ~clk_sy_r[2];
  assign fall  = ~clk_sy_r[1] & clk_sy_r[2];
  assign nbit  = (bit_r == TMSP_LAST_BIT) ? 4'h0 : bit_r + 4'h1;
  assign nslot = (bit_r == TMSP_LAST_BIT) ? slot_r + 3'h1 : slot_r;
  assign setup = psel_i & ~penable_i;
  assign wr_en = psel_i & penable_i & pready_o & pwrite_i & rd_ok_r;
  assign tx_start = mode & fall & (nbit == 4'h0) & slot_en_r[nslot]
                  & tx_full_r;

  // Pin synchronisers; the second stage is read, and for the clock also the third for edge detection
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      clk_sy_r <= 3'h0;
      fs_sy_r  <= 2'h0;
      din_sy_r <= 2'h0;
      ain_sy_r <= 2'h0;
    end
    else
    begin
      clk_sy_r <= {clk_sy_r[1:0], shared_serial_clock_i};
      fs_sy_r  <= {fs_sy_r[0], frame_sync_i};
      din_sy_r <= {din_sy_r[0], mux_receive_data_pin_i};
      ain_sy_r <= {ain_sy_r[0], shared_address_line_i};
    end
  end

  // Slot timing; frame sync marks bit 0 of slot 0
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      bit_r  <= TMSP_LAST_BIT;
      slot_r <= TMSP_RST_CUR_SLOT;
    end
    else if (rise)
    begin
      if (fs_sy_r[1])
      begin
        bit_r  <= 4'h0;
        slot_r <= 3'h0;
      end
      else
      begin
        bit_r  <= nbit;
        slot_r <= nslot;
      end
    end
  end

  // Receive path; own slots are skipped
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rx_shift_r   <= 16'h0000;
      rx_addr_r    <= 8'h00;
      last_addr_r  <= 8'h00;
      last_match_r <= 1'b0;
      rx_hold_r    <= 16'h0000;
      ev.rx_done   <= 1'b0;
    end
    else
    begin
      ev.rx_done <= 1'b0;
      if (mode && rise)
      begin
        rx_shift_r <= {rx_shift_r[14:0], din_sy_r[1]};
        if ((fs_sy_r[1] ? 4'h0 : nbit) < TMSP_ADDR_END)
          rx_addr_r <= {rx_addr_r[6:0], ain_sy_r[1]};
        if (!fs_sy_r[1] && nbit == TMSP_LAST_BIT)
        begin
          last_addr_r  <= rx_addr_r;
          last_match_r <= |(rx_addr_r & addr_pair_r[7:0]);
          if (|(rx_addr_r & addr_pair_r[7:0]) && tx_st_r != TMSP_TX_SEND)
          begin
            rx_hold_r  <= {rx_shift_r[14:0], din_sy_r[1]};
            ev.rx_done <= 1'b1;
          end
        end
      end
    end
  end

  // Transmit state; drives only through an enabled, loaded slot
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      tx_st_r <= TMSP_TX_IDLE;
    else
    begin
      case (tx_st_r)
        TMSP_TX_IDLE:
          if (tx_start)
            tx_st_r <= TMSP_TX_SEND;
        TMSP_TX_SEND:
          if (!mode || (fall && nbit == 4'h0 && !tx_start))
            tx_st_r <= TMSP_TX_IDLE;
        default:
          tx_st_r <= TMSP_TX_IDLE;
      endcase
    end
  end

  // Shift out on falling edges of the shared clock
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_shift_r  <= 16'h0000;
      tx_addr_r   <= 8'h00;
      ev.tx_moved <= 1'b0;
    end
    else
    begin
      ev.tx_moved <= 1'b0;
      if (tx_start)
      begin
        tx_shift_r  <= tx_hold_r;
        tx_addr_r   <= addr_pair_r[15:8];
        ev.tx_moved <= 1'b1;
      end
      else if (fall && tx_st_r == TMSP_TX_SEND)
      begin
        tx_shift_r <= {tx_shift_r[14:0], 1'b0};
        tx_addr_r  <= {tx_addr_r[6:0], 1'b0};
      end
    end
  end

  // Pin drivers; released outside enabled slots
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mux_transmit_data_pin_o <= 1'b0;
      address_out_o           <= 1'b0;
      data_oe_n_o             <= 1'b1;
      address_oe_n_o          <= 1'b1;
    end
    else
    begin
      if (tx_start)
      begin
        mux_transmit_data_pin_o <= tx_hold_r[TMSP_WORD_W-1];
        address_out_o           <= addr_pair_r[15];
      end
      else if (fall && tx_st_r == TMSP_TX_SEND)
      begin
        mux_transmit_data_pin_o <= tx_shift_r[14];
        address_out_o           <= tx_addr_r[6];
      end
      // Mode drop releases the lines at once, not at slot end
      data_oe_n_o    <= ~(tx_start | (mode & tx_st_r == TMSP_TX_SEND
                      & ~(fall & nbit == 4'h0)));
      address_oe_n_o <= ~(tx_start | (mode & tx_st_r == TMSP_TX_SEND
                      & ~(fall & nbit == 4'h0)));
    end
  end

  // Control, slot, address and interrupt mask registers
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_r      <= TMSP_RST_CTRL;
      slot_en_r   <= TMSP_RST_SLOT;
      addr_pair_r <= TMSP_RST_ADDR;
      mask_r      <= TMSP_RST_FLAG;
    end
    else if (wr_en)
    begin
      if (hit(paddr_i, TMSP_OFF_CTRL))
        ctrl_r <= pwdata_i[15:0];
      if (hit(paddr_i, TMSP_OFF_SLOT))
        slot_en_r <= pwdata_i[TMSP_SLOTS-1:0];
      if (hit(paddr_i, TMSP_OFF_ADDR))
        addr_pair_r <= pwdata_i[15:0];
      if (hit(paddr_i, TMSP_OFF_IMASK))
        mask_r <= pwdata_i[1:0];
    end
  end

  // Transmit holding; a load wins over a software write
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_hold_r <= 16'h0000;
      tx_full_r <= 1'b0;
    end
    else if (tx_start)
      tx_full_r <= 1'b0;
    else if (wr_en && hit(paddr_i, TMSP_OFF_TXHOLD))
    begin
      tx_hold_r <= pwdata_i[15:0];
      tx_full_r <= 1'b1;
    end
  end

  // Sticky flags: a set wins over a write-one clear
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      flag_r <= TMSP_RST_FLAG;
    else
    begin
      flag_r <= (flag_r & ~((wr_en && hit(paddr_i, TMSP_OFF_IFLAG))
              ? pwdata_i[1:0] : 2'h0)) | {ev.tx_moved, ev.rx_done};
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(flag_r & mask_r);
  end

  // Read mux; holding registers vanish in multiprocessing mode
  always_comb
  begin
    rd_val  = 32'h0000_0000;
    reg_hit = 1'b1;
    case (paddr_i)
      TMSP_OFF_CTRL:   rd_val[15:0] = ctrl_r;
      TMSP_OFF_SLOT:   rd_val[7:0]  = slot_en_r;
      TMSP_OFF_ADDR:   rd_val[15:0] = addr_pair_r;
      TMSP_OFF_RXHOLD:
      begin
        reg_hit = ~mode;
        if (!mode)
          rd_val[15:0] = rx_hold_r;
      end
      TMSP_OFF_TXHOLD: reg_hit = ~mode;
      TMSP_OFF_ASTAT:
      begin
        rd_val[7:0] = last_addr_r;
        rd_val[TMSP_ST_SLOT_LO +: 3] = slot_r;
        rd_val[TMSP_ST_MATCH]  = last_match_r;
        rd_val[TMSP_ST_TXACT]  = (tx_st_r == TMSP_TX_SEND);
        rd_val[TMSP_ST_TXFULL] = tx_full_r;
      end
      TMSP_OFF_IFLAG:  rd_val[1:0] = flag_r;
      TMSP_OFF_IMASK:  rd_val[1:0] = mask_r;
      default:         reg_hit = 1'b0;
    endcase
  end

  // One access cycle: answer is prepared during setup
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      rd_ok_r   <= 1'b0;
    end
    else
    begin
      pready_o  <= setup;
      pslverr_o <= setup & ~reg_hit;
      rd_ok_r   <= setup & reg_hit;
      prdata_o  <= (setup && !pwrite_i) ? rd_val : 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

/* logic/tmsp_pkg.sv */
/*
  Package of the multiplexed serial port: register map, field positions,
  reset values and link framing constants.
  Assumes an APB master with 32-bit data and a byte-addressed map.
*/
`default_nettype none
package tmsp_pkg;
  // Register byte offsets
  localparam logic [7:0] TMSP_OFF_CTRL   = 8'h00;
  localparam logic [7:0] TMSP_OFF_SLOT   = 8'h04;
  localparam logic [7:0] TMSP_OFF_ADDR   = 8'h08;
  localparam logic [7:0] TMSP_OFF_RXHOLD = 8'h0C;
  localparam logic [7:0] TMSP_OFF_TXHOLD = 8'h10;
  localparam logic [7:0] TMSP_OFF_ASTAT  = 8'h14;
  localparam logic [7:0] TMSP_OFF_IFLAG  = 8'h18;
  localparam logic [7:0] TMSP_OFF_IMASK  = 8'h1C;
  // Field layout
  localparam int TMSP_MODE_BIT   = 0;
  localparam int TMSP_SLOTS      = 8;
  localparam int TMSP_WORD_W     = 16;
  localparam int TMSP_ADDR_W     = 8;
  localparam int TMSP_FLAG_RX    = 0;
  localparam int TMSP_FLAG_TX    = 1;
  localparam int TMSP_ST_SLOT_LO = 8;
  localparam int TMSP_ST_MATCH   = 11;
  localparam int TMSP_ST_TXACT   = 12;
  localparam int TMSP_ST_TXFULL  = 13;
  // Reset values
  localparam logic [15:0] TMSP_RST_CTRL = 16'h0000;
  localparam logic [7:0]  TMSP_RST_SLOT = 8'h00;
  localparam logic [2:0]  TMSP_RST_CUR_SLOT = 3'h7;
  localparam logic [15:0] TMSP_RST_ADDR = 16'h0000;
  localparam logic [1:0]  TMSP_RST_FLAG = 2'h0;
  // Framing
  localparam logic [3:0] TMSP_LAST_BIT = 4'hF;
  localparam logic [3:0] TMSP_ADDR_END = 4'h8;

  typedef struct packed {
    logic tx_moved;
    logic rx_done;
  } tmsp_ev_t;

  typedef enum logic [1:0] {
    TMSP_TX_IDLE = 2'b01,
    TMSP_TX_SEND = 2'b10
  } tmsp_tx_st_t;
endpackage
`default_nettype wire

/* verif/tmsp_checker.sv */
/* Checker of the port's APB answers and pin drive.
   Bound to tmsp_port; sees its ports only. */
`timescale 1ns/1ns
`default_nettype none
module tmsp_checker
  import tmsp_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        data_oe_n_o,
  input wire logic        address_oe_n_o
);
  logic mode_r;
  wire  setup = psel_i && !penable_i;
  // Mode seen from accepted control writes only
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      mode_r <= 1'b0;
    else if (psel_i && penable_i && pready_o && pwrite_i && !pslverr_o
             && paddr_i == TMSP_OFF_CTRL)
      mode_r <= pwdata_i[TMSP_MODE_BIT];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_ready_after_setup: assert property (setup |=> pready_o)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside answer");
  a_upper_zero: assert property (pready_o |-> prdata_o[31:16] == 16'h0)
    else $error("upper read bits set");
  a_unmapped_err: assert property (setup && paddr_i >= 8'h20 |=> pslverr_o)
    else $error("unmapped access not refused");
  a_hold_blocked: assert property (setup && mode_r &&
    (paddr_i == TMSP_OFF_RXHOLD || paddr_i == TMSP_OFF_TXHOLD) |=> pslverr_o)
    else $error("holding register reachable in mode");
  a_slot_reserved: assert property (setup && !pwrite_i &&
    paddr_i == TMSP_OFF_SLOT |=> prdata_o[15:8] == 8'h00)
    else $error("reserved slot bits read");
  a_drive_mode: assert property (!data_oe_n_o |-> mode_r || $past(mode_r))
    else $error("data driven outside mode");
  a_addr_with_data: assert property (!address_oe_n_o |-> !data_oe_n_o)
    else $error("address driven without data");
endmodule
bind tmsp_port tmsp_checker chk_u (.clk_i, .reset_n_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
  .data_oe_n_o, .address_oe_n_o);
`default_nettype wire

/* verif/tmsp_far_end.sv */
/* Far-end processor on the shared bus: makes whole frames of bus clock and
   frame sync, each begun while run_i is high, sends one word per frame in slot_i, records what
   the port drove. Assumes no third party on the lines. */
`timescale 1ns/1ns
`default_nettype none
module tmsp_far_end
(
  input  wire logic        run_i,
  input  wire logic [2:0]  slot_i,
  input  wire logic [15:0] word_i,
  input  wire logic [7:0]  dest_i,
  input  wire logic        dat_i,
  input  wire logic        dat_oe_n_i,
  input  wire logic        adr_i,
  input  wire logic        adr_oe_n_i,
  output var  logic        sclk_o,
  output var  logic        fsync_o,
  output wire logic        dat_o,
  output wire logic        adr_o,
  output var  logic [15:0] cap_word_o,
  output var  logic [7:0]  cap_dest_o,
  output var  logic [2:0]  cap_slot_o
);
  logic drv, pd, pa, idle;
  int   b;
  // Released lines toggle so a stale value never looks valid
  assign dat_o = !dat_oe_n_i ? dat_i : drv ? pd : idle;
  assign adr_o = !adr_oe_n_i ? adr_i : (drv && b % 16 < 8) ? pa : !idle;
  initial
  begin
    {sclk_o, fsync_o, drv, pd, pa, idle, b} = '0;
    {cap_word_o, cap_dest_o, cap_slot_o} = '0;
    forever
    begin
      wait (run_i);
      // Keeps bus edges off the sampling edge of the port clock
      #2;
      // Clock stands still between frames
      for (b = 0; b < 128; b++)
      begin
        sclk_o = 1'b0;
        fsync_o = (b == 0);
        drv = (b / 16 == slot_i);
        pd = word_i[15 - b % 16];
        pa = dest_i[7 - b % 8];
        idle = !idle;
        #40;
        sclk_o = 1'b1;
        if (!dat_oe_n_i)
        begin
          cap_word_o = {cap_word_o[14:0], dat_o};
          cap_slot_o = 3'(b / 16);
          if (b % 16 < 8)
            cap_dest_o = {cap_dest_o[6:0], adr_o};
        end
        #40;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
/* Testbench of tmsp_port: APB register tests and one linked run
   against the far-end model. Assumes the checker is bound. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import tmsp_pkg::*;
  logic        clk_i, reset_n_i, psel, pen, pwr, run;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, sclk, fsync, dat, adr, irq;
  wire logic        d_o, d_oe_n, a_o, a_oe_n;
  wire logic [15:0] cap_word;
  wire logic [7:0]  cap_dest;
  wire logic [2:0]  cap_slot;
  int errors, checks;
  tmsp_port dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .shared_serial_clock_i(sclk), .frame_sync_i(fsync),
    .mux_receive_data_pin_i(dat), .mux_transmit_data_pin_o(d_o),
    .data_oe_n_o(d_oe_n), .shared_address_line_i(adr),
    .address_out_o(a_o), .address_oe_n_o(a_oe_n), .irq_o(irq));
  // Own address 02 avoids the 55 pattern of idle slots
  tmsp_far_end far_u (.run_i(run), .slot_i(3'h5), .word_i(16'h5A3C),
    .dest_i(8'h06), .dat_i(d_o), .dat_oe_n_i(d_oe_n), .adr_i(a_o),
    .adr_oe_n_i(a_oe_n), .sclk_o(sclk), .fsync_o(fsync), .dat_o(dat),
    .adr_o(adr), .cap_word_o(cap_word), .cap_dest_o(cap_dest),
    .cap_slot_o(cap_slot));
  task automatic wrap_up;
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] e,
                     input logic ee);
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1)
      @(posedge clk_i);
    if (!w)
      chk($sformatf("rdata %h", a), e, prdata);
    chk($sformatf("pslverr %h", a), 32'(ee), 32'(pslverr));
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    #200000;
    errors++;
    wrap_up();
  end
  initial
  begin
    {reset_n_i, psel, pen, pwr, run, paddr, pwdata} = '0;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 8; i++)
      if (i != 4)
        apb(0, 8'(4 * i), 0, (i == 5) ? 32'h0700 : 32'h0, 0);
    apb(1, TMSP_OFF_SLOT, 32'hFF08, 0, 0);
    apb(0, TMSP_OFF_SLOT, 0, 32'h08, 0);
    apb(1, TMSP_OFF_ADDR, 32'h0502, 0, 0);
    apb(0, TMSP_OFF_ADDR, 0, 32'h0502, 0);
    apb(0, 8'h20, 0, 0, 1);
    apb(1, TMSP_OFF_TXHOLD, 32'hB6E1, 0, 0);
    apb(0, TMSP_OFF_ASTAT, 0, 32'h2700, 0);
    apb(1, TMSP_OFF_IMASK, 32'h3, 0, 0);
    apb(1, TMSP_OFF_CTRL, 32'h1, 0, 0);
    apb(0, TMSP_OFF_RXHOLD, 0, 0, 1);
    apb(1, TMSP_OFF_TXHOLD, 32'h1234, 0, 1);
    run <= 1'b1;
    repeat (2100) @(posedge clk_i);
    run <= 1'b0;
    repeat (1100) @(posedge clk_i);
    chk("irq", 1, irq);
    apb(0, TMSP_OFF_ASTAT, 0, 32'h0755, 0);
    apb(0, TMSP_OFF_IFLAG, 0, 32'h3, 0);
    chk("sent word", 32'hB6E1, cap_word);
    chk("sent dest", 32'h05, cap_dest);
    chk("sent slot", 32'h3, cap_slot);
    apb(1, TMSP_OFF_IMASK, 32'h2, 0, 0);
    repeat (2) @(posedge clk_i);
    chk("irq masked", 1, irq);
    apb(1, TMSP_OFF_IFLAG, 32'h2, 0, 0);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 0, irq);
    apb(0, TMSP_OFF_IFLAG, 0, 32'h1, 0);
    apb(1, TMSP_OFF_CTRL, 32'h0, 0, 0);
    apb(0, TMSP_OFF_RXHOLD, 0, 32'h5A3C, 0);
    wrap_up();
  end
endmodule
`default_nettype wire
